// *** hdl/fsac_pkg.sv ***
// package for the fault status and address capture block
package fsac_pkg;
    // register byte offsets
    localparam logic [11:0] memory_fault_address_off = 12'hd34;
    localparam logic [11:0] bus_fault_address_off    = 12'hd38;
    localparam logic [11:0] hard_fault_status_off    = 12'hd2c;
    localparam logic [11:0] fault_valid_off          = 12'hd40;
    localparam logic [11:0] irq_status_off           = 12'hd44;
    localparam logic [11:0] irq_mask_off             = 12'hd48;
    localparam logic [11:0] bus_error_off            = 12'hd4c;
    // hard fault status field positions
    localparam int forced_bit = 30;
    localparam int vector_read_fault_flag_bit   = 1;
    // fault valid register field positions
    localparam int mvalid_bit = 0;
    localparam int bvalid_bit = 1;
    // interrupt event positions
    localparam int ev_forced  = 0;
    localparam int ev_vector_read_fault_flag    = 1;
    localparam int ev_mem     = 2;
    localparam int ev_bus     = 3;
    localparam int ev_priv    = 4;
    localparam int ev_width   = 5;
    localparam logic [31:0] zero_word = 32'h0000_0000;
    localparam logic [2:0]  size_byte = 3'h1;

    // register bus request
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
        logic        priv;
    } fsac_bus_type;

    // fault events from the core
    typedef struct packed {
        logic        escalate;   // configurable fault escalated
        logic        vector_read_fault_flag_err;   // bus error on a vector fetch
        logic        mem_fault;
        logic [31:0] mem_addr;   // faulting aligned sub-access
        logic        bus_fault;
        logic [31:0] bus_addr;   // address requested by the instruction
    } fsac_fault_type;
endpackage : fsac_pkg

// *** hdl/fsac_w1c.sv ***
// sticky flag with write-one-to-clear, set winning over clear
`timescale 1ns/1ps
module fsac_w1c #(
    parameter int width = 1
) (
    input  wire logic             core_clk,  // clock
    input  wire logic             rst_n,     // async reset, low
    input  wire logic [width-1:0] set,       // hardware events
    input  wire logic [width-1:0] clr,       // software clear strobes
    output logic      [width-1:0] flag       // sticky flags
);
    // set wins so an event in the clear cycle is kept
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag <= '0;
        end else begin
            flag <= (flag & ~clr) | set;
        end
    end
endmodule : fsac_w1c

// *** hdl/fsac_top.sv ***
// fault status and fault address capture with register port
// Contract
// - set forced flag when a configurable fault escalates to hard fault
// - memory fault address holds the faulting aligned sub-access address
// - captured memory fault address may be anywhere inside the access range
// - memory fault address meaningful only while its valid flag is set
// - bus fault address holds the address requested by the instruction
// - bus fault address meaningful only while its valid flag is set
// - address registers reachable from privileged mode only
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
module fsac_top (
    input  wire logic                    core_clk,  // 100 MHz clock
    input  wire logic                    rst_n,     // async reset, low
    input  wire fsac_pkg::fsac_bus_type  bus,       // register request
    output logic [31:0]                  rdata,     // read data, cycle after rd
    input  wire fsac_pkg::fsac_fault_type fault,    // fault events
    output logic                         hard_fault_req, // pulse to hard fault entry
    output logic                         irq        // level interrupt
);
    typedef struct packed {
        logic [31:0] mem_addr;
        logic [31:0] bus_addr;
        logic        mvalid;
        logic        bvalid;
        logic [31:0] rdata;
        logic        hf_req;
        logic [fsac_pkg::ev_width-1:0] mask;
        logic        priv_err;
    } fsac_state_type;

    fsac_state_type state;
    fsac_state_type next_state;

    logic [1:0]                    hf_flag;
    logic [1:0]                    hf_set;
    logic [1:0]                    hf_clr;
    logic [fsac_pkg::ev_width-1:0] ev_flag;
    logic [fsac_pkg::ev_width-1:0] ev_set;
    logic [fsac_pkg::ev_width-1:0] ev_clr;
    logic                          priv_bad;

    // address match for a privileged-only register
    function automatic logic fsac_is_addr_reg(input logic [11:0] a);
        return (a == fsac_pkg::memory_fault_address_off) ||
               (a == fsac_pkg::bus_fault_address_off);
    endfunction : fsac_is_addr_reg

    function automatic logic fsac_hit(input fsac_pkg::fsac_bus_type b,
                                      input logic [11:0] a);
        return b.wr && b.addr == a && b.priv;
    endfunction : fsac_hit

    assign priv_bad = (bus.wr || bus.rd) && !bus.priv && fsac_is_addr_reg(bus.addr);

    // hard fault flags: [1] forced, [0] vector read fault
    assign hf_set = {fault.escalate, fault.vector_read_fault_flag_err};
    assign hf_clr = fsac_hit(bus, fsac_pkg::hard_fault_status_off) ?
                    {bus.wdata[fsac_pkg::forced_bit], bus.wdata[fsac_pkg::vector_read_fault_flag_bit]} : 2'h0;

    fsac_w1c #(.width(2)) u_hf (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .set      (hf_set),
        .clr      (hf_clr),
        .flag     (hf_flag)
    );

    // interrupt sources, one sticky bit each
    assign ev_set = {priv_bad, fault.bus_fault, fault.mem_fault,
                     fault.vector_read_fault_flag_err, fault.escalate};
    assign ev_clr = fsac_hit(bus, fsac_pkg::irq_status_off) ?
                    bus.wdata[fsac_pkg::ev_width-1:0] : '0;

    fsac_w1c #(.width(fsac_pkg::ev_width)) u_ev (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .set      (ev_set),
        .clr      (ev_clr),
        .flag     (ev_flag)
    );

    // next state: captures, software writes, read mux
    always_comb begin
        next_state          = state;
        next_state.hf_req   = fault.vector_read_fault_flag_err;
        next_state.priv_err = priv_bad;
        next_state.rdata    = fsac_pkg::zero_word;
        // software writes first so a capture in the same cycle wins
        if (fsac_hit(bus, fsac_pkg::memory_fault_address_off)) begin
            next_state.mem_addr = bus.wdata;
        end
        if (fsac_hit(bus, fsac_pkg::bus_fault_address_off)) begin
            next_state.bus_addr = bus.wdata;
        end
        if (fsac_hit(bus, fsac_pkg::irq_mask_off)) begin
            next_state.mask = bus.wdata[fsac_pkg::ev_width-1:0];
        end
        if (fsac_hit(bus, fsac_pkg::fault_valid_off)) begin
            if (bus.wdata[fsac_pkg::mvalid_bit]) begin
                next_state.mvalid = 1'b0;
            end
            if (bus.wdata[fsac_pkg::bvalid_bit]) begin
                next_state.bvalid = 1'b0;
            end
        end
        // the core reports the aligned sub-access, so any byte of the access may appear
        if (fault.mem_fault) begin
            next_state.mem_addr = fault.mem_addr;
            next_state.mvalid   = 1'b1;
        end
        if (fault.bus_fault) begin
            next_state.bus_addr = fault.bus_addr;
            next_state.bvalid   = 1'b1;
        end
        // read data; unprivileged reads of address registers return zero
        if (bus.rd) begin
            case (bus.addr)
                fsac_pkg::memory_fault_address_off: begin
                    next_state.rdata = bus.priv ? state.mem_addr : fsac_pkg::zero_word;
                end
                fsac_pkg::bus_fault_address_off: begin
                    next_state.rdata = bus.priv ? state.bus_addr : fsac_pkg::zero_word;
                end
                fsac_pkg::hard_fault_status_off: begin
                    next_state.rdata[fsac_pkg::forced_bit] = hf_flag[1];
                    next_state.rdata[fsac_pkg::vector_read_fault_flag_bit]   = hf_flag[0];
                end
                fsac_pkg::fault_valid_off: begin
                    next_state.rdata[fsac_pkg::mvalid_bit] = state.mvalid;
                    next_state.rdata[fsac_pkg::bvalid_bit] = state.bvalid;
                end
                fsac_pkg::irq_status_off: begin
                    next_state.rdata[fsac_pkg::ev_width-1:0] = ev_flag;
                end
                fsac_pkg::irq_mask_off: begin
                    next_state.rdata[fsac_pkg::ev_width-1:0] = state.mask;
                end
                fsac_pkg::bus_error_off: begin
                    next_state.rdata[0] = state.priv_err;
                end
                default: begin
                    next_state.rdata = fsac_pkg::zero_word;
                end
            endcase
        end
    end

    // one register for the whole state
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign rdata          = state.rdata;
    assign hard_fault_req = state.hf_req;
    assign irq            = |(ev_flag & state.mask);

    // checks
    chk_forced_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        fault.escalate |=> hf_flag[1])
        else $error("forced flag not set");
    chk_vector_read_fault_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        fault.vector_read_fault_flag_err |=> hf_flag[0] && hard_fault_req)
        else $error("vector fault not flagged");
    chk_vector_read_fault_flag_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        (fsac_hit(bus, fsac_pkg::hard_fault_status_off) && bus.wdata[fsac_pkg::vector_read_fault_flag_bit]
         && !fault.vector_read_fault_flag_err) |=> !hf_flag[0])
        else $error("vector flag not cleared");
    chk_mem_capture: assert property (@(posedge core_clk) disable iff (!rst_n)
        fault.mem_fault |=> state.mem_addr == $past(fault.mem_addr))
        else $error("memory fault address not captured");
    chk_mem_range: assert property (@(posedge core_clk) disable iff (!rst_n)
        fault.mem_fault |=> (state.mem_addr - $past(fault.mem_addr)) < {29'h0, fsac_pkg::size_byte})
        else $error("memory fault address outside access");
    chk_mem_valid: assert property (@(posedge core_clk) disable iff (!rst_n)
        fault.mem_fault |=> state.mvalid)
        else $error("memory valid not set");
    chk_bus_capture: assert property (@(posedge core_clk) disable iff (!rst_n)
        fault.bus_fault |=> state.bus_addr == $past(fault.bus_addr))
        else $error("bus fault address not captured");
    chk_bus_valid: assert property (@(posedge core_clk) disable iff (!rst_n)
        fault.bus_fault |=> state.bvalid)
        else $error("bus valid not set");
    chk_priv_read: assert property (@(posedge core_clk) disable iff (!rst_n)
        (bus.rd && !bus.priv && fsac_is_addr_reg(bus.addr)) |=> rdata == fsac_pkg::zero_word)
        else $error("unprivileged read returned data");
    chk_priv_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        (bus.wr && !bus.priv && bus.addr == fsac_pkg::bus_fault_address_off && !fault.bus_fault)
        |=> $stable(state.bus_addr))
        else $error("unprivileged write took effect");

    // hard fault flags: a flag stays set until software writes a one to it,
    // and never rises without its event; set wins over a clear in one cycle
    chk_forced_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        (fsac_hit(bus, fsac_pkg::hard_fault_status_off) && bus.wdata[fsac_pkg::forced_bit]
         && !fault.escalate) |=> !hf_flag[1])
        else $error("forced flag not cleared");
    chk_forced_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        (hf_flag[1] && !(fsac_hit(bus, fsac_pkg::hard_fault_status_off)
         && bus.wdata[fsac_pkg::forced_bit])) |=> hf_flag[1])
        else $error("forced flag lost");
    chk_forced_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!hf_flag[1] && !fault.escalate) |=> !hf_flag[1])
        else $error("forced flag set without escalation");
    chk_vector_read_fault_flag_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        (hf_flag[0] && !(fsac_hit(bus, fsac_pkg::hard_fault_status_off)
         && bus.wdata[fsac_pkg::vector_read_fault_flag_bit])) |=> hf_flag[0])
        else $error("vector flag lost");
    chk_vector_read_fault_flag_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!hf_flag[0] && !fault.vector_read_fault_flag_err) |=> !hf_flag[0])
        else $error("vector flag set without fetch error");
    chk_vector_read_fault_flag_req_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
        !fault.vector_read_fault_flag_err |=> !hard_fault_req)
        else $error("hard fault request without fetch error");

    // read back of the hard fault flags, one cycle after the strobe
    chk_forced_read: assert property (@(posedge core_clk) disable iff (!rst_n)
        (bus.rd && bus.addr == fsac_pkg::hard_fault_status_off)
        |=> rdata[fsac_pkg::forced_bit] == $past(hf_flag[1]))
        else $error("forced flag read back wrong");
    chk_vector_read_fault_flag_read: assert property (@(posedge core_clk) disable iff (!rst_n)
        (bus.rd && bus.addr == fsac_pkg::hard_fault_status_off)
        |=> rdata[fsac_pkg::vector_read_fault_flag_bit] == $past(hf_flag[0]))
        else $error("vector flag read back wrong");

    // interrupt status follows every fault event
    chk_forced_event: assert property (@(posedge core_clk) disable iff (!rst_n)
        fault.escalate |=> ev_flag[fsac_pkg::ev_forced])
        else $error("forced event not recorded");
    chk_vector_read_fault_flag_event: assert property (@(posedge core_clk) disable iff (!rst_n)
        fault.vector_read_fault_flag_err |=> ev_flag[fsac_pkg::ev_vector_read_fault_flag])
        else $error("vector event not recorded");
    chk_mem_event: assert property (@(posedge core_clk) disable iff (!rst_n)
        fault.mem_fault |=> ev_flag[fsac_pkg::ev_mem])
        else $error("memory event not recorded");
    chk_bus_event: assert property (@(posedge core_clk) disable iff (!rst_n)
        fault.bus_fault |=> ev_flag[fsac_pkg::ev_bus])
        else $error("bus event not recorded");
    chk_priv_event: assert property (@(posedge core_clk) disable iff (!rst_n)
        priv_bad |=> ev_flag[fsac_pkg::ev_priv] && state.priv_err)
        else $error("privilege violation not recorded");

    // captured addresses only move on a fault or a privileged write;
    // a stale address must never look fresh to the handler
    chk_mem_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!fault.mem_fault && !fsac_hit(bus, fsac_pkg::memory_fault_address_off))
        |=> $stable(state.mem_addr))
        else $error("memory fault address changed unasked");
    chk_bus_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!fault.bus_fault && !fsac_hit(bus, fsac_pkg::bus_fault_address_off))
        |=> $stable(state.bus_addr))
        else $error("bus fault address changed unasked");
    chk_mem_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        (fsac_hit(bus, fsac_pkg::memory_fault_address_off) && !fault.mem_fault)
        |=> state.mem_addr == $past(bus.wdata))
        else $error("privileged memory address write lost");
    chk_bus_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        (fsac_hit(bus, fsac_pkg::bus_fault_address_off) && !fault.bus_fault)
        |=> state.bus_addr == $past(bus.wdata))
        else $error("privileged bus address write lost");
    chk_priv_mem_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        (bus.wr && !bus.priv && bus.addr == fsac_pkg::memory_fault_address_off
         && !fault.mem_fault) |=> $stable(state.mem_addr))
        else $error("unprivileged memory address write took effect");
    chk_mem_read: assert property (@(posedge core_clk) disable iff (!rst_n)
        (bus.rd && bus.priv && bus.addr == fsac_pkg::memory_fault_address_off)
        |=> rdata == $past(state.mem_addr))
        else $error("memory fault address read back wrong");
    chk_bus_read: assert property (@(posedge core_clk) disable iff (!rst_n)
        (bus.rd && bus.priv && bus.addr == fsac_pkg::bus_fault_address_off)
        |=> rdata == $past(state.bus_addr))
        else $error("bus fault address read back wrong");

    // valid flags: set by a capture, cleared by a one, otherwise held
    chk_mvalid_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state.mvalid && !(fsac_hit(bus, fsac_pkg::fault_valid_off)
         && bus.wdata[fsac_pkg::mvalid_bit])) |=> state.mvalid)
        else $error("memory valid lost");
    chk_mvalid_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!state.mvalid && !fault.mem_fault) |=> !state.mvalid)
        else $error("memory valid set without fault");
    chk_mvalid_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        (fsac_hit(bus, fsac_pkg::fault_valid_off) && bus.wdata[fsac_pkg::mvalid_bit]
         && !fault.mem_fault) |=> !state.mvalid)
        else $error("memory valid not cleared");
    chk_bvalid_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state.bvalid && !(fsac_hit(bus, fsac_pkg::fault_valid_off)
         && bus.wdata[fsac_pkg::bvalid_bit])) |=> state.bvalid)
        else $error("bus valid lost");
    chk_bvalid_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!state.bvalid && !fault.bus_fault) |=> !state.bvalid)
        else $error("bus valid set without fault");
    chk_bvalid_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        (fsac_hit(bus, fsac_pkg::fault_valid_off) && bus.wdata[fsac_pkg::bvalid_bit]
         && !fault.bus_fault) |=> !state.bvalid)
        else $error("bus valid not cleared");
    chk_mvalid_read: assert property (@(posedge core_clk) disable iff (!rst_n)
        (bus.rd && bus.addr == fsac_pkg::fault_valid_off)
        |=> rdata[fsac_pkg::mvalid_bit] == $past(state.mvalid))
        else $error("memory valid read back wrong");
    chk_bvalid_read: assert property (@(posedge core_clk) disable iff (!rst_n)
        (bus.rd && bus.addr == fsac_pkg::fault_valid_off)
        |=> rdata[fsac_pkg::bvalid_bit] == $past(state.bvalid))
        else $error("bus valid read back wrong");
endmodule : fsac_top

// *** dv/testbench.sv ***
// self-checking bench for the fault status and address capture block
`timescale 1ns/1ps
module testbench;
    logic                     core_clk;        // 100 MHz clock
    logic                     rst_n;           // async reset, low
    fsac_pkg::fsac_bus_type   bus;             // register request
    logic [31:0]              rdata;           // read data
    fsac_pkg::fsac_fault_type fault;           // fault events
    logic                     hard_fault_req;  // hard fault entry pulse
    logic                     irq;             // level interrupt
    int                       miscompares;     // mismatches seen
    int                       samples_checked; // comparisons made

    fsac_top uut (
        .core_clk       (core_clk),
        .rst_n          (rst_n),
        .bus            (bus),
        .rdata          (rdata),
        .fault          (fault),
        .hard_fault_req (hard_fault_req),
        .irq            (irq)
    );

    // clock generator, 10 ns period
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // one-cycle write strobe
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic p);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, priv: p};
        @(posedge core_clk);
        bus <= '{addr: 12'h000, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b0, priv: 1'b0};
        #1; // let the flops settle before a caller samples outputs
    endtask : wr

    // one-cycle read strobe; data is looked at only in the cycle after it
    task automatic rd(input string n, input logic [11:0] a, input logic p, input logic [31:0] e);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1, priv: p};
        @(posedge core_clk);
        bus <= '{addr: 12'h000, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b0, priv: 1'b0};
        #1;
        chk(n, e, rdata);
    endtask : rd

    // one fault pulse of the chosen kind with its address
    task automatic ev(input int k, input logic [31:0] a);
        @(posedge core_clk);
        fault.escalate  <= (k == 0);
        fault.vector_read_fault_flag_err  <= (k == 1);
        fault.mem_fault <= (k == 2);
        fault.bus_fault <= (k == 3);
        fault.mem_addr  <= a;
        fault.bus_addr  <= a;
        @(posedge core_clk);
        fault <= '0;
        #1;
    endtask : ev

    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        #50000;
        miscompares++;
        finish_test();
    end

    // main sequence
    initial begin
        miscompares = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        bus = '0;
        fault = '0;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        rd("hard_status", fsac_pkg::hard_fault_status_off, 1'b1, 32'h0000_0000);
        wr(fsac_pkg::irq_mask_off, 32'h0000_001f, 1'b1);
        ev(0, 32'h0000_0000);
        chk("irq_forced", 32'h1, {31'h0, irq});
        rd("forced", fsac_pkg::hard_fault_status_off, 1'b1, 32'h4000_0000);
        wr(fsac_pkg::hard_fault_status_off, 32'h4000_0000, 1'b1);
        rd("forced_clr", fsac_pkg::hard_fault_status_off, 1'b1, 32'h0000_0000);
        wr(fsac_pkg::irq_status_off, 32'h0000_001f, 1'b1);
        chk("irq_clr", 32'h0, {31'h0, irq});
        // vector fetch error must enter the hard fault handler next cycle
        ev(1, 32'h0000_0000);
        chk("hf_req", 32'h1, {31'h0, hard_fault_req});
        @(posedge core_clk);
        #1;
        chk("hf_req_end", 32'h0, {31'h0, hard_fault_req});
        rd("vector_read_fault_flag", fsac_pkg::hard_fault_status_off, 1'b1, 32'h0000_0002);
        wr(fsac_pkg::hard_fault_status_off, 32'h0000_0002, 1'b1);
        rd("vector_read_fault_flag_clr", fsac_pkg::hard_fault_status_off, 1'b1, 32'h0000_0000);
        // unaligned sub-access addresses are captured as given
        rd("valid_none", fsac_pkg::fault_valid_off, 1'b1, 32'h0000_0000);
        ev(2, 32'h2000_0013);
        rd("mem_addr", fsac_pkg::memory_fault_address_off, 1'b1, 32'h2000_0013);
        rd("mem_valid", fsac_pkg::fault_valid_off, 1'b1, 32'h0000_0001);
        ev(3, 32'h2000_0101);
        rd("bus_addr", fsac_pkg::bus_fault_address_off, 1'b1, 32'h2000_0101);
        rd("bus_valid", fsac_pkg::fault_valid_off, 1'b1, 32'h0000_0003);
        rd("irq_stat", fsac_pkg::irq_status_off, 1'b1, 32'h0000_000e);
        wr(fsac_pkg::irq_status_off, 32'h0000_001f, 1'b1);
        // privileged write, then unprivileged access refused
        wr(fsac_pkg::memory_fault_address_off, 32'h1234_5678, 1'b1);
        rd("mem_wr", fsac_pkg::memory_fault_address_off, 1'b1, 32'h1234_5678);
        rd("unpriv_rd", fsac_pkg::memory_fault_address_off, 1'b0, 32'h0000_0000);
        wr(fsac_pkg::bus_fault_address_off, 32'hdead_0000, 1'b0);
        rd("unpriv_wr", fsac_pkg::bus_fault_address_off, 1'b1, 32'h2000_0101);
        rd("priv_evt", fsac_pkg::irq_status_off, 1'b1, 32'h0000_0010);
        chk("irq_priv", 32'h1, {31'h0, irq});
        wr(fsac_pkg::irq_mask_off, 32'h0000_0000, 1'b1);
        chk("irq_mask", 32'h0, {31'h0, irq});
        rd("unmapped", 12'hd50, 1'b1, 32'h0000_0000);
        finish_test();
    end
endmodule : testbench
